// ===== uflv_pkg.sv
// Package for the UART FIFO fill-level and threshold interrupt block.
// Assumes a 32-bit APB slave in the peripheral clock domain.
//
// Functional notes
// - Receive count is 6 bits, 0 to 32, read in receive buffer control.
// - A push that would exceed capacity is dropped; write enable deasserted.
// - Receive request asserted while receive count >= receive threshold.
// - Transmit free count is 6 bits, 32 empty to 0 full, read back.
// - Transmit request asserted while free count >= transmit threshold.
// - Writes to read-only or reserved bits do nothing and complete cleanly.
// - Receive control write loads threshold bits 4:0; read returns count.
// - Transmit control write loads threshold bits 4:0; read returns free.
// - Transmit request shows in status bit 7, receive request in bit 6.
package uflv_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W  = 6;
  localparam int unsigned THR_W  = 5;
  localparam logic [CNT_W-1:0] FIFO_DEPTH = 6'h20;

  localparam logic [ADDR_W-1:0] OFS_STATUS  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_RX_CTRL = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_TX_CTRL = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST  = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 12'h024;

  localparam int unsigned STAT_TX_BIT = 7;
  localparam int unsigned STAT_RX_BIT = 6;

  localparam int unsigned EV_RX_THR  = 0;
  localparam int unsigned EV_TX_THR  = 1;
  localparam int unsigned EV_RX_DROP = 2;
  localparam int unsigned EV_TX_DROP = 3;
  localparam int unsigned EV_W       = 4;

  localparam logic [CNT_W-1:0] RX_CNT_RST = 6'h00;
  localparam logic [THR_W-1:0] THR_RST    = 5'h00;
  localparam logic [EV_W-1:0]  IRQ_RST    = 4'h0;
endpackage : uflv_pkg

// ===== uflv_cnt_if.sv
// Interface between the top and each occupancy counter.
// Assumes one clock domain; the top drives push, pop and threshold.
`timescale 1ns/1ps
`default_nettype none
interface uflv_cnt_if;
  logic                      push;
  logic                      pop;
  logic [uflv_pkg::THR_W-1:0] thr;
  logic [uflv_pkg::CNT_W-1:0] level;
  logic                      accept;
  logic                      above;
  modport ctr (input push, pop, thr, output level, accept, above);
  modport usr (output push, pop, thr, input level, accept, above);
endinterface : uflv_cnt_if
`default_nettype wire

// ===== uflv_level.sv
// Occupancy counter with capacity guard and threshold compare.
// Assumes push and pop are one-cycle strobes on i_mclk.
`timescale 1ns/1ps
`default_nettype none
module uflv_level (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  // Counter port
  uflv_cnt_if.ctr   c
);
  logic [uflv_pkg::CNT_W-1:0] cnt_r;
  logic [uflv_pkg::CNT_W-1:0] cnt_nxt;
  logic                       acc;
  logic                       pop_ok;

  always_comb begin
    pop_ok = c.pop && (cnt_r != uflv_pkg::RX_CNT_RST);
    // Pop frees a slot in the same cycle, so a full FIFO may swap
    acc = c.push && ((cnt_r != uflv_pkg::FIFO_DEPTH) || pop_ok);
    cnt_nxt = cnt_r;
    if (acc && !pop_ok) begin
      cnt_nxt = cnt_r + 6'h01;
    end else if (pop_ok && !acc) begin
      cnt_nxt = cnt_r - 6'h01;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cnt_r <= uflv_pkg::RX_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign c.level  = cnt_r;
  assign c.accept = acc;
  assign c.above  = cnt_r >= {1'b0, c.thr};
endmodule : uflv_level
`default_nettype wire

// ===== uflv_top.sv
// Top of the UART FIFO level block: APB slave, two level counters,
// threshold requests and a sticky interrupt register.
// Assumes push/pop strobes come from the FIFO data paths, one per cycle.
`timescale 1ns/1ps
`default_nettype none
module uflv_top (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  // FIFO strobes
  input  wire logic        i_rx_push,
  input  wire logic        i_rx_pop,
  input  wire logic        i_tx_push,
  input  wire logic        i_tx_pop,
  output var  logic        o_rx_wr_en,
  output var  logic        o_tx_wr_en,
  // Requests and interrupt
  output var  logic        o_rx_irq_pending,
  output var  logic        o_tx_irq_pending,
  output var  logic        o_irq
);
  uflv_cnt_if rx_c ();
  uflv_cnt_if tx_c ();

  logic [uflv_pkg::THR_W-1:0] rx_thr_r;
  logic [uflv_pkg::THR_W-1:0] rx_thr_nxt;
  logic [uflv_pkg::THR_W-1:0] tx_thr_r;
  logic [uflv_pkg::THR_W-1:0] tx_thr_nxt;
  logic [uflv_pkg::EV_W-1:0]  ist_r;
  logic [uflv_pkg::EV_W-1:0]  ist_nxt;
  logic [uflv_pkg::EV_W-1:0]  msk_r;
  logic [uflv_pkg::EV_W-1:0]  msk_nxt;
  logic [uflv_pkg::EV_W-1:0]  ev;
  logic                       rx_req_r;
  logic                       tx_req_r;
  logic                       rx_wr_r;
  logic                       tx_wr_r;
  logic                       irq_r;
  logic                       irq_nxt;
  logic [31:0]                rdata_r;
  logic [31:0]                rdata_nxt;
  logic                       ready_r;
  logic                       ready_nxt;
  logic                       wr_acc;
  logic                       rd_acc;
  logic [uflv_pkg::CNT_W-1:0] tx_free;

  uflv_level u_rx (.i_mclk(i_mclk), .i_rstn(i_rstn), .c(rx_c.ctr));
  uflv_level u_tx (.i_mclk(i_mclk), .i_rstn(i_rstn), .c(tx_c.ctr));

  // Tx counter tracks occupancy; free slots are its complement
  assign tx_free = uflv_pkg::FIFO_DEPTH - tx_c.level;

  always_comb begin
    rx_c.push = i_rx_push;
    rx_c.pop  = i_rx_pop;
    rx_c.thr  = rx_thr_r;
    // Software should push only with free slots; guard anyway
    tx_c.push = i_tx_push;
    tx_c.pop  = i_tx_pop;
    tx_c.thr  = tx_thr_r;
  end

  // One-wait APB: ready is raised in the second access cycle
  assign wr_acc = i_psel && i_penable && i_pwrite && !ready_r;
  assign rd_acc = i_psel && i_penable && !i_pwrite && !ready_r;

  // Threshold and mask writes
  always_comb begin
    rx_thr_nxt = rx_thr_r;
    tx_thr_nxt = tx_thr_r;
    msk_nxt    = msk_r;
    if (wr_acc) begin
      unique case (i_paddr)
        uflv_pkg::OFS_RX_CTRL: rx_thr_nxt = i_pwdata[4:0];
        uflv_pkg::OFS_TX_CTRL: tx_thr_nxt = i_pwdata[4:0];
        uflv_pkg::OFS_IRQ_MSK: msk_nxt = i_pwdata[uflv_pkg::EV_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rx_thr_r <= uflv_pkg::THR_RST;
      tx_thr_r <= uflv_pkg::THR_RST;
      msk_r    <= uflv_pkg::IRQ_RST;
    end else begin
      rx_thr_r <= rx_thr_nxt;
      tx_thr_r <= tx_thr_nxt;
      msk_r    <= msk_nxt;
    end
  end

  // Compare on the current tx free count, not the occupancy
  logic tx_above;
  assign tx_above = tx_free >= {1'b0, tx_thr_r};

  // Sticky events: rising edge of each request, and dropped pushes
  always_comb begin
    ev = '0;
    ev[uflv_pkg::EV_RX_THR]  = rx_c.above && !rx_req_r;
    ev[uflv_pkg::EV_TX_THR]  = tx_above && !tx_req_r;
    ev[uflv_pkg::EV_RX_DROP] = i_rx_push && !rx_c.accept;
    ev[uflv_pkg::EV_TX_DROP] = i_tx_push && !tx_c.accept;
    ist_nxt = ist_r;
    if (wr_acc && i_paddr == uflv_pkg::OFS_IRQ_ST) begin
      ist_nxt = ist_r & ~i_pwdata[uflv_pkg::EV_W-1:0];
    end
    // Set wins over a clear in the same cycle
    ist_nxt = ist_nxt | ev;
    irq_nxt = |(ist_nxt & msk_nxt);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ist_r    <= uflv_pkg::IRQ_RST;
      irq_r    <= 1'b0;
      rx_req_r <= 1'b0;
      tx_req_r <= 1'b0;
      rx_wr_r  <= 1'b0;
      tx_wr_r  <= 1'b0;
    end else begin
      ist_r    <= ist_nxt;
      irq_r    <= irq_nxt;
      rx_req_r <= rx_c.above;
      tx_req_r <= tx_above;
      rx_wr_r  <= rx_c.accept;
      tx_wr_r  <= tx_c.accept;
    end
  end

  // Read mux; unmapped reads return zero, no error
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    ready_nxt = i_psel && i_penable && !ready_r;
    if (rd_acc) begin
      unique case (i_paddr)
        uflv_pkg::OFS_RX_CTRL:
          rdata_nxt[uflv_pkg::CNT_W-1:0] = rx_c.level;
        uflv_pkg::OFS_TX_CTRL:
          rdata_nxt[uflv_pkg::CNT_W-1:0] = tx_free;
        uflv_pkg::OFS_STATUS: begin
          rdata_nxt[uflv_pkg::STAT_TX_BIT] = tx_req_r;
          rdata_nxt[uflv_pkg::STAT_RX_BIT] = rx_req_r;
        end
        uflv_pkg::OFS_IRQ_ST:
          rdata_nxt[uflv_pkg::EV_W-1:0] = ist_r;
        uflv_pkg::OFS_IRQ_MSK:
          rdata_nxt[uflv_pkg::EV_W-1:0] = msk_r;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign o_prdata         = rdata_r;
  assign o_pready         = ready_r;
  assign o_pslverr        = 1'b0;
  assign o_rx_wr_en       = rx_wr_r;
  assign o_tx_wr_en       = tx_wr_r;
  assign o_rx_irq_pending = rx_req_r;
  assign o_tx_irq_pending = tx_req_r;
  assign o_irq            = irq_r;
endmodule : uflv_top
`default_nettype wire

// ===== uflv_properties.sv
// Checker for the FIFO level block, bound to uflv_top.
// Assumes only the top ports are visible, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module uflv_checker (
  input wire logic        i_mclk, i_rstn, i_psel, i_penable, i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata, o_prdata,
  input wire logic        o_pready, o_pslverr, i_rx_push, i_rx_pop,
  input wire logic        i_tx_push, i_tx_pop, o_rx_wr_en, o_tx_wr_en,
  input wire logic        o_rx_irq_pending, o_tx_irq_pending, o_irq
);
  logic [5:0] rc_r, rc_nxt, tc_r, tc_nxt;
  // Shadow occupancy; a pop on a full FIFO lets the push in
  function automatic logic [5:0] nx(logic [5:0] c, logic p, logic o);
    return c + 6'(p && (c < 6'h20 || o)) - 6'(o && c != 6'h00);
  endfunction : nx
  always_comb begin
    rc_nxt = nx(rc_r, i_rx_push, i_rx_pop);
    tc_nxt = nx(tc_r, i_tx_push, i_tx_pop);
  end
  always_ff @(posedge i_mclk) begin
    rc_r <= i_rstn ? rc_nxt : 6'h00;
    tc_r <= i_rstn ? tc_nxt : 6'h00;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence s_take; i_psel && i_penable && !o_pready; endsequence
  sequence s_rd(a); o_pready && !i_pwrite && i_paddr == a; endsequence
  a_no_error: assert property (o_pslverr == 1'b0)
    else $error("transfer error raised");
  a_ready_after: assert property (s_take |=> o_pready)
    else $error("pready missing");
  a_ready_once: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  a_rx_accept: assert property (
    i_rx_push && rc_r < 6'h20 |=> o_rx_wr_en) else $error("rx push lost");
  a_rx_full_drop: assert property (
    i_rx_push && !i_rx_pop && rc_r == 6'h20 |=> !o_rx_wr_en)
    else $error("rx overfill");
  a_tx_accept: assert property (
    i_tx_push && tc_r < 6'h20 |=> o_tx_wr_en) else $error("tx push lost");
  a_tx_full_drop: assert property (
    i_tx_push && !i_tx_pop && tc_r == 6'h20 |=> !o_tx_wr_en)
    else $error("tx overfill");
  a_rx_count_read: assert property (
    s_rd(uflv_pkg::OFS_RX_CTRL) |-> o_prdata == {26'h0, rc_r})
    else $error("rx count wrong");
  a_tx_free_read: assert property (
    s_rd(uflv_pkg::OFS_TX_CTRL) |-> o_prdata == {26'h0, 6'h20 - tc_r})
    else $error("tx free wrong");
endmodule : uflv_checker
bind uflv_top uflv_checker u_uflv_checker (.*);
`default_nettype wire

// ===== test_uflv_top.sv
// Self-checking bench for uflv_top: APB, FIFO strobes, interrupt.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module test_uflv_top;
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic        rdy, err, rxw, txw, rxp, txp, irq;
  logic [3:0]  stb = '0;
  int          miscompares = 0, samples_checked = 0;
  uflv_top u_uflv_top (.i_mclk(clk), .i_rstn(rstn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata),
    .o_prdata(rdata), .o_pready(rdy), .o_pslverr(err), .i_rx_push(stb[0]),
    .i_rx_pop(stb[1]), .i_tx_push(stb[2]), .i_tx_pop(stb[3]),
    .o_rx_wr_en(rxw), .o_tx_wr_en(txw), .o_rx_irq_pending(rxp),
    .o_tx_irq_pending(txp), .o_irq(irq));
  initial forever #20 clk = ~clk;
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = rdata;
    psel <= 0;
    pen <= 0;
  endtask : apb
  // Strobes land one edge after being driven; tail lets pending settle
  task st(logic [3:0] v, int n);
    repeat (n) begin
      @(posedge clk);
      stb <= v;
    end
    @(posedge clk);
    stb <= 4'h0;
    repeat (2) @(posedge clk);
  endtask : st
  task t_reset;
    apb(0, uflv_pkg::OFS_RX_CTRL, 0);
    chk("rx count", 32'h0000_0000, rd);
    apb(0, uflv_pkg::OFS_TX_CTRL, 0);
    chk("tx free", 32'h0000_0020, rd);
    apb(0, uflv_pkg::OFS_STATUS, 0);
    chk("status", 32'h0000_00c0, rd);
    apb(0, 12'h100, 0);
    chk("unmapped", 32'h0000_0000, rd);
  endtask : t_reset
  task t_rx;
    apb(1, uflv_pkg::OFS_RX_CTRL, 32'hffff_ffe5);
    apb(0, uflv_pkg::OFS_RX_CTRL, 0);
    chk("rx ctrl", 32'h0000_0000, rd);
    apb(1, uflv_pkg::OFS_IRQ_ST, 32'h0000_000f);
    apb(1, uflv_pkg::OFS_IRQ_MSK, 32'h0000_0004);
    st(4'h1, 4);
    chk("rx pend 4", 0, rxp);
    st(4'h1, 1);
    chk("rx pend 5", 1, rxp);
    st(4'h1, 27);
    chk("irq masked", 0, irq);
    st(4'h1, 1);
    apb(0, uflv_pkg::OFS_RX_CTRL, 0);
    chk("rx full", 32'h0000_0020, rd);
    chk("irq drop", 1, irq);
    apb(1, uflv_pkg::OFS_IRQ_ST, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk("irq clear", 0, irq);
    st(4'h2, 32);
    apb(0, uflv_pkg::OFS_RX_CTRL, 0);
    chk("rx empty", 32'h0000_0000, rd);
  endtask : t_rx
  task t_tx;
    apb(1, uflv_pkg::OFS_TX_CTRL, 32'h0000_001f);
    st(4'h4, 32);
    chk("tx pend full", 0, txp);
    st(4'h4, 1);
    apb(0, uflv_pkg::OFS_TX_CTRL, 0);
    chk("tx free full", 32'h0000_0000, rd);
    st(4'h8, 30);
    chk("tx pend 30", 0, txp);
    st(4'h8, 1);
    chk("tx pend 31", 1, txp);
  endtask : t_tx
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1;
    t_reset;
    t_rx;
    t_tx;
    conclude;
  end
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    conclude;
  end
endmodule : test_uflv_top
`default_nettype wire
